// File: pkg/fapm_params.svh
// Constants of the floppy auto power manager: offsets, bit positions,
// reset values and timing counts.
// Assumes a 200 MHz system clock and host offsets relative to the base.
//
// Behaviour
// - Configuration power bit forces direct powerdown.
// - Auto powerdown only while auto-enable bit set.
// - Idle timer starts once auto powerdown enabled.
// - Main status or data access restarts timer.
// - Entry needs motors off, status 80H, no interrupt.
// - Entry also needs head unload and 10 ms.
// - Disabling auto mode cancels timer and entry.
// - Rate select powerdown overrides auto powerdown.
// - Auto powerdown resumes after rate select wake.
// - Reset wake runs the normal reset sequence.
// - Register wake keeps all state intact.
// - Motor bit write wakes; output reg read does not.
// - Main status read or data access wakes.
// - Every wake restarts the 10 ms timer.
// - Non-waking registers stay live and retained.
// - Other listed offsets never wake the controller.
// - Soft reset bits wake; other rate select bits do not.
// - Drive pins disabled while powered down.
// - Host pins live; interrupt and request low.
// - Power-good pin gives chip-level powerdown.
// - Motor, select, write pins tristate; others driven.
`ifndef FAPM_PARAMS_SVH
`define FAPM_PARAMS_SVH

// ------------------------------------------------------------
// Host register offsets
// ------------------------------------------------------------
`define FAPM_OFS_STATUS_A 3'h0
`define FAPM_OFS_STATUS_B 3'h1
`define FAPM_OFS_DIGOUT 3'h2
`define FAPM_OFS_RATE_SEL 3'h4
`define FAPM_OFS_MAIN_STATUS 3'h4
`define FAPM_OFS_FIFO_DATA 3'h5
`define FAPM_OFS_DIG_IN 3'h7
`define FAPM_OFS_CFG_CTRL 3'h7

// ------------------------------------------------------------
// Field positions and values
// ------------------------------------------------------------
`define FAPM_CR0_FDC_POWER_BIT 3
`define FAPM_CR7_FDC_AUTO_BIT 7
`define FAPM_DIGOUT_MOTOR_MSB 7
`define FAPM_DIGOUT_MOTOR_LSB 4
`define FAPM_DIGOUT_RESET_N_BIT 2
`define FAPM_DIGOUT_SEL_MSB 1
`define FAPM_DIGOUT_SEL_LSB 0
`define FAPM_RATESEL_RESET_BIT 7
`define FAPM_RATESEL_PD_BIT 6
`define FAPM_MAIN_STATUS_IDLE 8'h80
`define FAPM_DIGOUT_RESET 8'h00

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define FAPM_IDLE_TIME_US 10000
`define FAPM_CLK_FREQ_MHZ 200
`define FAPM_IDLE_CYCLES (`FAPM_IDLE_TIME_US * `FAPM_CLK_FREQ_MHZ)

`endif

// File: pkg/fapm_pkg.sv
// Types of the floppy auto power manager.
// Assumes fapm_params.svh is compiled alongside.
package fapm_pkg;

	// ------------------------------------------------------------
	// Power state
	// ------------------------------------------------------------
	typedef enum logic [0:0] {
		FAPM_ACTIVE = 1'b0,
		FAPM_AUTO_DOWN = 1'b1
	} fapm_pm_t;

	// ------------------------------------------------------------
	// Idle timer state
	// ------------------------------------------------------------
	typedef struct packed {
		logic [31:0] count;
		logic expired;
	} fapm_timer_t;

	// ------------------------------------------------------------
	// Controller state, outputs included
	// ------------------------------------------------------------
	typedef struct packed {
		fapm_pm_t pm;
		logic [7:0] digout;
		logic rate_pd;
		logic pg_meta;
		logic pg_sync;
		logic powered_down;
		logic soft_reset;
		logic [3:0] motor;
		logic motor_oe_n;
		logic [3:0] dsel;
		logic dsel_oe_n;
		logic wdata;
		logic wdata_oe_n;
		logic wgate;
		logic wgate_oe_n;
		logic direction;
		logic step;
		logic head;
		logic density;
		logic [1:0] rate;
		logic irq;
		logic drq;
	} fapm_state_t;

endpackage

// File: design/fapm_idle_timer.sv
// Idle timer of the floppy auto power manager.
// Assumes enable and restart come from logic on clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "fapm_params.svh"

module fapm_idle_timer #(
	parameter logic [31:0] IDLE_CYCLES = `FAPM_IDLE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic enable,
	input wire logic restart,
	output logic expired
);

	// ------------------------------------------------------------
	// Elaboration check
	// ------------------------------------------------------------
	if (IDLE_CYCLES < 32'h0000_0002 || IDLE_CYCLES > 32'h7FFF_FFFF) begin : g_bad
		$error("idle cycle count out of range");
	end

	fapm_pkg::fapm_timer_t q;
	fapm_pkg::fapm_timer_t n;

	// Count up; expiry holds until cancelled or restarted
	always_comb begin
		n = q;
		if (!enable || restart) begin
			n.count = 32'h0000_0000;
			n.expired = 1'b0;
		end else if (q.count == IDLE_CYCLES - 32'h0000_0001) begin
			n.expired = 1'b1;
		end else begin
			n.count = q.count + 32'h0000_0001;
		end
	end

	// State register
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= n;
		end
	end

	assign expired = q.expired;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	property p_timer_restart;
		restart |=> !expired && q.count == 32'h0000_0000;
	endproperty
	a_timer_restart: assert property (p_timer_restart) else $error("restart did not clear timer");

	property p_timer_expiry;
		$rose(expired) |-> $past(q.count) == IDLE_CYCLES - 32'h0000_0001 && $past(enable);
	endproperty
	a_timer_expiry: assert property (p_timer_expiry) else $error("timer expired at wrong count");

endmodule
`default_nettype wire

// File: design/fapm_power_ctrl.sv
// Floppy controller power manager: direct, rate select, chip and auto
// powerdown, wake on qualifying host accesses, drive pin gating.
// Assumes host strobes and configuration bits come from logic on clk_sys;
// only the power-good pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
`include "fapm_params.svh"

module fapm_power_ctrl #(
	parameter logic [31:0] IDLE_CYCLES = `FAPM_IDLE_CYCLES
) (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic power_good_in,
	input wire logic [7:0] power_config_reg0,
	input wire logic [7:0] auto_pm_config_reg,
	input wire logic [2:0] host_addr,
	input wire logic host_rd,
	input wire logic host_wr,
	input wire logic [7:0] host_data_bus_in,
	input wire logic [7:0] core_main_status,
	input wire logic core_int,
	input wire logic core_drq,
	input wire logic head_unload_done,
	input wire logic core_write_data,
	input wire logic core_write_enable,
	input wire logic core_direction,
	input wire logic core_step,
	input wire logic core_head_select,
	input wire logic core_density_select,
	input wire logic [1:0] core_rate,
	output logic [7:0] digital_output_reg,
	output logic fdc_powered_down,
	output logic fdc_auto_down,
	output logic fdc_soft_reset,
	output logic [3:0] motor_enable_out,
	output logic motor_enable_oe_n,
	output logic [3:0] drive_select_out,
	output logic drive_select_oe_n,
	output logic write_data_out,
	output logic write_data_oe_n,
	output logic write_enable_out,
	output logic write_enable_oe_n,
	output logic direction_out,
	output logic step_out,
	output logic head_select_out,
	output logic density_select_out,
	output logic [1:0] rate_out,
	output logic floppy_irq_out,
	output logic floppy_dma_req
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Drive number to one-hot select line
	function automatic logic [3:0] fapm_onehot(input logic [1:0] sel);
		logic [3:0] v;
		v = 4'h0;
		v[sel] = 1'b1;
		return v;
	endfunction

	// Host access decode against one offset
	function automatic logic fapm_hit(input logic strobe, input logic [2:0] addr, input logic [2:0] ofs);
		return strobe && (addr == ofs);
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	fapm_pkg::fapm_state_t q;
	fapm_pkg::fapm_state_t n;

	logic timer_expired;
	logic timer_restart;
	logic auto_en;
	logic direct_pd;
	logic wr_digout;
	logic wr_rate;
	logic rd_main;
	logic data_acc;
	logic motor_wake;
	logic sw_reset;
	logic wake;
	logic rate_wake;
	logic idle_ok;
	logic pd;

	// ------------------------------------------------------------
	// Access decode
	// ------------------------------------------------------------

	// Only these four accesses matter; status A/B, input and
	// configuration control fall through without effect
	always_comb begin
		wr_digout = fapm_hit(host_wr, host_addr, `FAPM_OFS_DIGOUT);
		wr_rate = fapm_hit(host_wr, host_addr, `FAPM_OFS_RATE_SEL);
		rd_main = fapm_hit(host_rd, host_addr, `FAPM_OFS_MAIN_STATUS);
		data_acc = fapm_hit(host_rd || host_wr, host_addr, `FAPM_OFS_FIFO_DATA);
	end

	// Wake sources; a read of the output register is not one
	always_comb begin
		motor_wake = wr_digout
			&& (|host_data_bus_in[`FAPM_DIGOUT_MOTOR_MSB:`FAPM_DIGOUT_MOTOR_LSB]);
		sw_reset = (wr_digout && !host_data_bus_in[`FAPM_DIGOUT_RESET_N_BIT])
			|| (wr_rate && host_data_bus_in[`FAPM_RATESEL_RESET_BIT]);
		wake = motor_wake || rd_main || data_acc || sw_reset;
	end

	// ------------------------------------------------------------
	// Configuration and idle conditions
	// ------------------------------------------------------------

	// Power bit low means the floppy function is off
	assign direct_pd = !power_config_reg0[`FAPM_CR0_FDC_POWER_BIT];
	assign auto_en = auto_pm_config_reg[`FAPM_CR7_FDC_AUTO_BIT];

	// Rate select powerdown released by a reset or a write clearing it
	assign rate_wake = q.rate_pd && !n.rate_pd;

	// Every wake and every reset sends the idle count back to zero
	assign timer_restart = rd_main || data_acc || wake || rate_wake;

	// All entry conditions must hold in the same cycle; a wake in
	// that cycle wins so the access is never served while asleep
	always_comb begin
		idle_ok = auto_en
			&& (q.digout[`FAPM_DIGOUT_MOTOR_MSB:`FAPM_DIGOUT_MOTOR_LSB] == 4'h0)
			&& (core_main_status == `FAPM_MAIN_STATUS_IDLE)
			&& !core_int
			&& head_unload_done
			&& timer_expired
			&& !q.rate_pd
			&& !wake;
	end

	// ------------------------------------------------------------
	// Idle timer
	// ------------------------------------------------------------
	fapm_idle_timer #(
		.IDLE_CYCLES(IDLE_CYCLES)
	) u_timer (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.enable(auto_en),
		.restart(timer_restart),
		.expired(timer_expired)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		n = q;
		// Power-good passes two flops before anything reads it
		n.pg_meta = power_good_in;
		n.pg_sync = q.pg_meta;
		n.soft_reset = sw_reset;
		// Output register written in any power state and kept
		if (wr_digout) begin
			n.digout = host_data_bus_in;
		end
		if (wr_rate) begin
			n.rate_pd = host_data_bus_in[`FAPM_RATESEL_PD_BIT];
		end
		if (sw_reset) begin
			n.rate_pd = 1'b0;
		end
		// Waking touches nothing but the power state
		unique case (q.pm)
			fapm_pkg::FAPM_ACTIVE: begin
				if (idle_ok) begin
					n.pm = fapm_pkg::FAPM_AUTO_DOWN;
				end
			end
			fapm_pkg::FAPM_AUTO_DOWN: begin
				if (wake || !auto_en) begin
					n.pm = fapm_pkg::FAPM_ACTIVE;
				end
			end
		endcase
		// Any powerdown source gates the pins; power-good is read past its second flop only
		pd = (n.pm == fapm_pkg::FAPM_AUTO_DOWN) || direct_pd || n.rate_pd || !q.pg_sync;
		n.powered_down = pd;
		// Retained register contents steer the pins on wake
		n.motor = n.digout[`FAPM_DIGOUT_MOTOR_MSB:`FAPM_DIGOUT_MOTOR_LSB];
		n.dsel = fapm_onehot(n.digout[`FAPM_DIGOUT_SEL_MSB:`FAPM_DIGOUT_SEL_LSB]);
		n.wdata = core_write_data;
		n.wgate = core_write_enable;
		// Pins that reach the drive float so no current flows
		n.motor_oe_n = pd;
		n.dsel_oe_n = pd;
		n.wdata_oe_n = pd;
		n.wgate_oe_n = pd;
		// Local control pins stay driven through powerdown
		n.direction = core_direction;
		n.step = core_step;
		n.head = core_head_select;
		n.density = core_density_select;
		n.rate = core_rate;
		// Host side stays live; request lines forced low
		n.irq = core_int && !pd;
		n.drq = core_drq && !pd;
	end

	// ------------------------------------------------------------
	// State register
	// ------------------------------------------------------------

	// Reset comes up awake with drive pins floating until the third edge
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			q <= '0;
			q.digout <= `FAPM_DIGOUT_RESET;
			q.powered_down <= 1'b1;
			q.motor_oe_n <= 1'b1;
			q.dsel_oe_n <= 1'b1;
			q.wdata_oe_n <= 1'b1;
			q.wgate_oe_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign digital_output_reg = q.digout;
	assign fdc_powered_down = q.powered_down;
	assign fdc_auto_down = (q.pm == fapm_pkg::FAPM_AUTO_DOWN);
	assign fdc_soft_reset = q.soft_reset;
	assign motor_enable_out = q.motor;
	assign motor_enable_oe_n = q.motor_oe_n;
	assign drive_select_out = q.dsel;
	assign drive_select_oe_n = q.dsel_oe_n;
	assign write_data_out = q.wdata;
	assign write_data_oe_n = q.wdata_oe_n;
	assign write_enable_out = q.wgate;
	assign write_enable_oe_n = q.wgate_oe_n;
	assign direction_out = q.direction;
	assign step_out = q.step;
	assign head_select_out = q.head;
	assign density_select_out = q.density;
	assign rate_out = q.rate;
	assign floppy_irq_out = q.irq;
	assign floppy_dma_req = q.drq;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);

	// Direct powerdown bit reaches the power output next edge
	property p_direct_pd;
		direct_pd |=> fdc_powered_down;
	endproperty
	a_direct_pd: assert property (p_direct_pd) else $error("direct powerdown not applied");

	// Auto entry only with the enable bit set
	property p_auto_needs_enable;
		$rose(fdc_auto_down) |-> $past(auto_en);
	endproperty
	a_auto_needs_enable: assert property (p_auto_needs_enable) else $error("auto entry while disabled");

	// Disable cancels the timer and leaves auto powerdown
	property p_disable_cancels;
		!auto_en |=> !timer_expired && !fdc_auto_down;
	endproperty
	a_disable_cancels: assert property (p_disable_cancels) else $error("disable did not cancel");

	// Entry only with every idle condition met one edge earlier
	property p_entry_conditions;
		$rose(fdc_auto_down) |-> $past(core_main_status) == `FAPM_MAIN_STATUS_IDLE && !$past(core_int)
			&& $past(head_unload_done) && $past(timer_expired)
			&& $past(q.digout[`FAPM_DIGOUT_MOTOR_MSB:`FAPM_DIGOUT_MOTOR_LSB]) == 4'h0;
	endproperty
	a_entry_conditions: assert property (p_entry_conditions) else $error("auto entry with conditions unmet");

	// Rate select powerdown blocks auto entry
	property p_rate_override;
		q.rate_pd && !fdc_auto_down |=> !fdc_auto_down;
	endproperty
	a_rate_override: assert property (p_rate_override) else $error("auto entry under rate powerdown");

	// Wake access followed by restarted timer and no quick re-entry
	sequence s_asleep_wake;
		fdc_auto_down && (rd_main || data_acc || motor_wake);
	endsequence
	sequence s_awake_fresh;
		!fdc_auto_down && !timer_expired;
	endsequence
	property p_wake_restart;
		s_asleep_wake |=> s_awake_fresh ##1 !fdc_auto_down;
	endproperty
	a_wake_restart: assert property (p_wake_restart) else $error("wake or timer restart missing");

	// Output register read alone keeps the controller asleep
	property p_read_no_wake;
		fdc_auto_down && auto_en && host_rd && !host_wr && host_addr == `FAPM_OFS_DIGOUT |=> fdc_auto_down;
	endproperty
	a_read_no_wake: assert property (p_read_no_wake) else $error("output register read woke block");

	// Drive pins float whenever the power output is set
	property p_drive_pins;
		fdc_powered_down |-> motor_enable_oe_n && drive_select_oe_n && write_data_oe_n && write_enable_oe_n;
	endproperty
	a_drive_pins: assert property (p_drive_pins) else $error("drive pin driven in powerdown");

	// Interrupt and request held low while down
	property p_host_lines_low;
		fdc_powered_down |-> !floppy_irq_out && !floppy_dma_req;
	endproperty
	a_host_lines_low: assert property (p_host_lines_low) else $error("request line high in powerdown");

	// Power-good loss reaches the power output within three edges
	property p_power_good;
		!power_good_in |-> ##[1:3] fdc_powered_down;
	endproperty
	a_power_good: assert property (p_power_good) else $error("power-good loss not applied");

	// Soft reset bit pulses reset and wakes
	property p_soft_reset_wake;
		sw_reset |=> fdc_soft_reset && !fdc_auto_down && !q.rate_pd;
	endproperty
	a_soft_reset_wake: assert property (p_soft_reset_wake) else $error("soft reset did not wake");

	// Writes while asleep are kept for the wake
	property p_retained_write;
		fdc_powered_down && wr_digout |=> digital_output_reg == $past(host_data_bus_in);
	endproperty
	a_retained_write: assert property (p_retained_write) else $error("write lost in powerdown");

endmodule
`default_nettype wire

// File: testbench/fapm_drive_model.sv
// Drive side of the floppy pins: resolves tristated motor and select lines.
// Assumes pins and enables come from the power manager on clk_sys.
`timescale 1ns/1ps
`default_nettype none

module fapm_drive_model (
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic [3:0] motor_enable_out,
	input wire logic motor_enable_oe_n,
	input wire logic [3:0] drive_select_out,
	input wire logic drive_select_oe_n,
	output logic [3:0] motor_pin,
	output logic [3:0] select_pin
);
	typedef struct packed {
		logic [3:0] motor;
		logic [3:0] dsel;
	} fapm_drive_t;
	fapm_drive_t st;
	fapm_drive_t next_st;

	// Remember the last driven level of each group
	always_comb begin
		next_st = st;
		if (!motor_enable_oe_n) begin
			next_st.motor = motor_enable_out;
		end
		if (!drive_select_oe_n) begin
			next_st.dsel = drive_select_out;
		end
	end

	// No pulls on these lines, so a released pin must not look still driven
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	// Released pins show the inverse of the last driven level
	assign motor_pin = motor_enable_oe_n ? ~st.motor : motor_enable_out;
	assign select_pin = drive_select_oe_n ? ~st.dsel : drive_select_out;
endmodule
`default_nettype wire

// File: testbench/fdc_auto_power_mgmt_test.sv
// Bench of the floppy power manager: random host bytes and core pins,
// with wake, entry and pin corner cases.
// Assumes a 20 cycle idle count and the drive model on the pins.
`timescale 1ns/1ps
`default_nettype none
`include "fapm_params.svh"

module fdc_auto_power_mgmt_test;
	localparam int IDLE = 20;
	localparam logic [3:0] NW [6] = '{4'h0, 4'h1, 4'h2, 4'h7, 4'hF, 4'hC};
	localparam logic [11:0] WK [6] = '{12'h400, 12'h500, 12'hD5A, 12'hA15, 12'hA00, 12'hC80};
	integer seed;
	int error_cnt, cmp_count, n, k;
	logic [7:0] d, prev;
	logic clk_sys, rst_n, power_good_in, host_rd, host_wr, core_int, core_drq, head_unload_done;
	logic [7:0] power_config_reg0, auto_pm_config_reg, host_data_bus_in, core_main_status;
	logic [2:0] host_addr;
	logic core_write_data, core_write_enable, core_direction, core_step, core_head_select, core_density_select;
	logic [1:0] core_rate, rate_out;
	logic [7:0] digital_output_reg;
	logic fdc_powered_down, fdc_auto_down, fdc_soft_reset, motor_enable_oe_n, drive_select_oe_n;
	logic [3:0] motor_enable_out, drive_select_out, motor_pin, select_pin;
	logic write_data_out, write_data_oe_n, write_enable_out, write_enable_oe_n, direction_out, step_out;
	logic head_select_out, density_select_out, floppy_irq_out, floppy_dma_req;

	// Short idle count keeps each entry at about 20 cycles
	fapm_power_ctrl #(.IDLE_CYCLES(32'(IDLE))) fapm_power_ctrl_i (
		.clk_sys, .rst_n, .power_good_in, .power_config_reg0, .auto_pm_config_reg, .host_addr, .host_rd,
		.host_wr, .host_data_bus_in, .core_main_status, .core_int, .core_drq, .head_unload_done,
		.core_write_data, .core_write_enable, .core_direction, .core_step, .core_head_select,
		.core_density_select, .core_rate, .digital_output_reg, .fdc_powered_down, .fdc_auto_down,
		.fdc_soft_reset, .motor_enable_out, .motor_enable_oe_n, .drive_select_out, .drive_select_oe_n,
		.write_data_out, .write_data_oe_n, .write_enable_out, .write_enable_oe_n, .direction_out,
		.step_out, .head_select_out, .density_select_out, .rate_out, .floppy_irq_out, .floppy_dma_req
	);

	fapm_drive_model fapm_drive_model_i (.clk_sys, .rst_n, .motor_enable_out, .motor_enable_oe_n,
		.drive_select_out, .drive_select_oe_n, .motor_pin, .select_pin);

	// 200 MHz system clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// Core pin levels change every cycle so stale forwarding shows
	always @(posedge clk_sys) begin
		{core_write_data, core_write_enable, core_direction, core_step, core_head_select,
			core_density_select, core_rate} <= 8'($random(seed));
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic conclude();
		$display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	// One host strobe; effects are looked at one settle step after it is taken
	task automatic acc(input logic wr, input logic [2:0] a, input logic [7:0] v);
		@(posedge clk_sys);
		host_wr <= wr;
		host_rd <= ~wr;
		host_addr <= a;
		host_data_bus_in <= v;
		@(posedge clk_sys);
		host_wr <= 1'b0;
		host_rd <= 1'b0;
		#1;
	endtask

	task automatic wait_down(output int cyc);
		cyc = 0;
		while (fdc_auto_down !== 1'b1 && cyc < 200) begin
			tick();
			cyc++;
		end
		if (cyc >= 200) begin
			error_cnt++;
			$display("mismatch auto_down expected 1 seen timeout");
			conclude();
		end
	endtask

	task automatic stay_up();
		logic hit;
		hit = 1'b0;
		repeat (IDLE + 10) begin
			tick();
			hit = hit | (fdc_auto_down !== 1'b0);
		end
		chk("stay_up", 8'h00, 8'(hit));
	endtask

	function automatic logic exp_sr(input logic [11:0] w);
		return w[11] && ((w[10:8] == 3'h2 && !w[`FAPM_DIGOUT_RESET_N_BIT]) || (w[10:8] == 3'h4 && w[7]));
	endfunction

	function automatic logic [3:0] sel1h(input logic [1:0] s);
		return 4'h1 << s;
	endfunction

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		seed = 37;
		error_cnt = 0;
		cmp_count = 0;
		{rst_n, host_rd, host_wr, core_int, host_addr, host_data_bus_in} = '0;
		{power_good_in, core_drq, head_unload_done} = 3'h7;
		power_config_reg0 = 8'h08;
		auto_pm_config_reg = 8'h80;
		core_main_status = `FAPM_MAIN_STATUS_IDLE;
		{core_write_data, core_write_enable, core_direction, core_step, core_head_select,
			core_density_select, core_rate} = '0;
		repeat (3) @(posedge clk_sys);
		rst_n <= 1'b1;
		tick();
		chk("digital_output_reg", `FAPM_DIGOUT_RESET, digital_output_reg);
		wait_down(n);
		chk("entry_cycles", 8'h01, 8'(n >= IDLE - 2 && n <= IDLE + 6));
		chk("oe_n", 8'h0F, {4'h0, motor_enable_oe_n, drive_select_oe_n, write_data_oe_n, write_enable_oe_n});
		chk("irq_drq", 8'h00, {6'h00, floppy_irq_out, floppy_dma_req});
		d = {2'h0, core_direction, core_step, core_head_select, core_density_select, core_rate};
		prev = {6'h00, core_write_data, core_write_enable};
		tick();
		chk("drive_pins", d, {2'h0, direction_out, step_out, head_select_out, density_select_out, rate_out});
		chk("write_pins", prev, {6'h00, write_data_out, write_enable_out});
		$display("test entry done");
		// Accesses that must leave the controller asleep
		for (k = 0; k < 6; k++) begin
			acc(NW[k][3], NW[k][2:0], 8'($random(seed)) & 8'h3F);
			chk("nowake", 8'h01, 8'(fdc_auto_down));
		end
		d = 8'h04 | (8'($random(seed)) & 8'h0B);
		acc(1'b1, 3'h2, d);
		chk("nowake_digout", 8'h01, 8'(fdc_auto_down));
		chk("digital_output_reg", d, digital_output_reg);
		prev = d;
		$display("test nowake done");
		// Each waking access, then re-entry after a fresh idle count
		for (k = 0; k < 6; k++) begin
			wait_down(n);
			acc(WK[k][11], WK[k][10:8], WK[k][7:0]);
			chk("wake", 8'h00, 8'(fdc_auto_down));
			chk("soft_reset", 8'(exp_sr(WK[k])), 8'(fdc_soft_reset));
			if (!WK[k][11]) begin
				chk("kept_digout", prev, digital_output_reg);
			end
			if (WK[k][11:8] == 4'hA) begin
				chk("pins", {WK[k][7:4], sel1h(WK[k][1:0])}, {motor_pin, select_pin});
			end
			acc(1'b1, 3'h2, 8'h04);
			prev = 8'h04;
			wait_down(n);
			chk("reentry", 8'h01, 8'(n >= IDLE - 4 && n <= IDLE + 4));
		end
		$display("test wake done");
		// Frequent status reads keep the timer from running out
		acc(1'b0, 3'h5, 8'h00);
		for (k = 0; k < 4; k++) begin
			repeat (IDLE / 2) @(posedge clk_sys);
			acc(1'b0, 3'h4, 8'h00);
		end
		chk("restart", 8'h00, 8'(fdc_auto_down));
		// One missing idle condition at a time blocks entry
		for (k = 0; k < 4; k++) begin
			core_main_status <= (k == 0) ? 8'h80 ^ (8'($random(seed)) | 8'h01) : 8'h80;
			core_int <= (k == 1);
			head_unload_done <= (k != 2);
			acc(1'b1, 3'h2, (k == 3) ? 8'h84 : 8'h04);
			stay_up();
			chk("irq_drq", {6'h00, k == 1, 1'b1}, {6'h00, floppy_irq_out, floppy_dma_req});
		end
		core_main_status <= 8'h80;
		core_int <= 1'b0;
		head_unload_done <= 1'b1;
		acc(1'b1, 3'h2, 8'h04);
		wait_down(n);
		$display("test blockers done");
		// Rate select powerdown overrides, then auto mode returns
		acc(1'b0, 3'h5, 8'h00);
		acc(1'b1, 3'h4, 8'h40);
		chk("rate_pd", 8'h01, 8'(fdc_powered_down));
		stay_up();
		acc(1'b1, 3'h4, 8'h00);
		wait_down(n);
		chk("rate_wake", 8'h01, 8'(n >= IDLE - 4 && n <= IDLE + 4));
		// Disabling auto mode leaves powerdown and blocks entry
		auto_pm_config_reg <= 8'h00;
		tick();
		tick();
		chk("auto_off", 8'h00, 8'(fdc_auto_down));
		stay_up();
		auto_pm_config_reg <= 8'h80 | (8'($random(seed)) & 8'h7F);
		wait_down(n);
		// Host's next command comes long after a wake, with the controller back down, and wakes it
		acc(1'b0, 3'h4, 8'h00);
		repeat (1600) @(posedge clk_sys);
		acc(1'b1, 3'h5, 8'($random(seed)));
		chk("cmd_wake", 8'h00, 8'(fdc_auto_down));
		$display("test auto modes done");
		// Direct and chip powerdown act with auto mode off
		auto_pm_config_reg <= 8'h00;
		power_config_reg0 <= 8'h00;
		repeat (3) tick();
		chk("direct_pd", 8'h1F, {3'h0, fdc_powered_down, motor_enable_oe_n, drive_select_oe_n,
			write_data_oe_n, write_enable_oe_n});
		power_config_reg0 <= 8'h08;
		repeat (1600) @(posedge clk_sys);
		#1;
		chk("direct_up", 8'h00, 8'(fdc_powered_down));
		power_good_in <= 1'b0;
		repeat (3) tick();
		chk("chip_pd", 8'h01, 8'(fdc_powered_down));
		$display("test direct done");
		conclude();
	end

	// Cuts a hang short
	initial begin
		repeat (50000) @(posedge clk_sys);
		error_cnt++;
		$display("mismatch run_length expected end seen timeout");
		conclude();
	end
endmodule
`default_nettype wire
